// ===== logic/ee_cmd_slave.sv
// serial eeprom command slave: bit engine, shared address counter, page buffer, ecc store
`timescale 1ns/10ps
`include "ee_map.svh"
// Functional notes
// - write: select with rw 0 acked, then two acked address bytes, then data
// - first address byte is bits 15..8, second is bits 7..0
// - only a stop right after a data ack starts the write cycle
// - after the write cycle the counter points past the last modified byte
// - while writing, sda released, starts ignored, nothing acknowledged
// - write protect high: array data bytes refused, array unchanged
// - page write stores 1 to 128 bytes of one page in one cycle
// - in-page address wraps to 0 at the page end
// - in-page address advances by one after each acknowledged data byte
// - id page write: type 1011, bit 10 low, bits 6..0 pick the byte
// - locked id page refuses id page data bytes
// - lock command: type 1011, bit 10 high, data bit 1 set; locks until reset
// - each aligned four-byte group carries a code correcting one bit on read
// - writing any byte of a group rewrites the whole group and check bits
// - reads behave the same whatever write protect says
// - no master ack after an output byte releases sda and goes standby
// - random read: dummy write of address, repeated start, read select
// - current read outputs the byte at the counter, then increments it
// - one counter serves array and id page accesses
// - sequential read outputs consecutive bytes, counter wraps to zero
// - write protect still lets select and address bytes be acknowledged
// - select answered only when bits 3..1 match straps; type 1010 or 1011
// - truncated id page write acks the data byte only when unlocked
module ee_cmd_slave
  import ee_pkg::*;
#(
  parameter int ADDR_W = `EE_ADDR_W,
  parameter int PAGE_BYTES = `EE_PAGE_BYTES,
  parameter int FIFO_DEPTH = `EE_FIFO_DEPTH,
  parameter int TW_CYCLES = `EE_TW_MS * 1000000 / `EE_CLK_NS
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic write_protect_input,
  input wire logic chip_select_strap_bit2,
  input wire logic chip_select_strap_bit1,
  input wire logic chip_select_strap_bit0,
  output logic write_busy,
  output logic id_page_locked
);
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int PGROUPS = PAGE_BYTES / 4;
  localparam int MEM_GROUPS = 2 ** (ADDR_W - 2);
  localparam int NG = MEM_GROUPS + PGROUPS;
  localparam int GW = $clog2(NG);
  localparam int CW = $clog2(TW_CYCLES + 1);

  if (ADDR_W < 11 || ADDR_W > 16 || PAGE_BYTES < 4 || (1 << PW) != PAGE_BYTES
      || PW >= ADDR_W || TW_CYCLES < 1)
  begin : g_bad_param
    $error("ee_cmd_slave parameters out of range");
  end

  // pin synchronisers, all six inputs come from outside the clock domain
  logic [5:0] pin_raw;
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic scl_q;
  logic sda_q;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] strap;

  localparam logic [5:0] PIN_IDLE = `EE_PIN_IDLE;
  assign pin_raw = {scl, sda_in, write_protect_input,
                    chip_select_strap_bit2, chip_select_strap_bit1, chip_select_strap_bit0};

  for (genvar i = 0; i < 6; i++)
  begin : g_sync
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        pin_meta[i] <= PIN_IDLE[i];
        pin_sync[i] <= PIN_IDLE[i];
      end
      else
      begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
      end
    end
  end

  assign scl_s = pin_sync[5];
  assign sda_s = pin_sync[4];
  assign wp_s = pin_sync[3];
  assign strap = pin_sync[2:0];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_ev = scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev = scl_s && scl_q && !sda_q && sda_s;

  // ecc: six check bits hold the xor of the 1-based positions of the set data bits
  function automatic logic [5:0] ee_ecc_gen(input logic [31:0] d);
    logic [5:0] s;
    s = '0;
    for (int i = 0; i < 32; i++)
      if (d[i])
        s = s ^ 6'(i + 1);
    return s;
  endfunction : ee_ecc_gen

  // limitation: a flipped check bit alone can steer a wrong data correction
  function automatic logic [31:0] ee_ecc_fix(input logic [31:0] d, input logic [5:0] c);
    logic [5:0] syn;
    logic [31:0] r;
    r = d;
    syn = c ^ ee_ecc_gen(d);
    for (int i = 0; i < 32; i++)
      if (syn == 6'(i + 1))
        r[i] = ~r[i];
    return r;
  endfunction : ee_ecc_fix

  // id page sits in the groups just above the array
  function automatic logic [GW-1:0] grp_of(input logic id, input logic [ADDR_W-1:0] a);
    return id ? GW'(MEM_GROUPS + int'(a[PW-1:2])) : GW'(a[ADDR_W-1:2]);
  endfunction : grp_of

  function automatic logic ee_sel_hit(input logic [7:0] b, input logic [2:0] cs);
    return (b[7:4] == `EE_TYPE_MEM || b[7:4] == `EE_TYPE_ID) && b[3:1] == cs;
  endfunction : ee_sel_hit

  logic [31:0] mem [0:NG-1];
  logic [5:0] eccm [0:NG-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pmask;

  ee_phase_t phase;
  ee_kind_t kind;
  logic [3:0] bitcnt;
  logic ack_phase;
  logic acked;
  logic master_ack;
  logic [7:0] shreg;
  logic [7:0] txbyte;
  logic sel_id;
  logic [7:0] addr_hi;
  logic [ADDR_W-1:0] ctr;
  logic wr_armed;
  logic lock_pend;
  logic [CW-1:0] busy_cnt;

  logic live;
  logic byte_done;
  logic slot_end;
  logic lock_cmd;
  logic ack_ok;
  logic commit;
  logic page_clr;
  logic [GW-1:0] rd_grp;
  logic [31:0] rd_word;
  logic [7:0] rd_byte;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [PW+7:0] f_out_data;

  assign live = !write_busy && !start_ev && !stop_ev;
  assign byte_done = live && scl_fall && phase != EE_IDLE && !ack_phase && bitcnt == 4'h8;
  assign slot_end = live && scl_fall && ack_phase;
  assign lock_cmd = sel_id && ctr[`EE_LOCK_ADDR_BIT];
  assign commit = write_busy && busy_cnt == '0;
  assign page_clr = slot_end && phase == EE_RX && kind == EE_K_SEL && acked && !shreg[`EE_RW_BIT];

  // read path is the same whatever write protect says
  assign rd_grp = grp_of(sel_id, ctr);
  assign rd_word = ee_ecc_fix(mem[rd_grp], eccm[rd_grp]);
  assign rd_byte = rd_word[{ctr[1:0], 3'h0} +: 8];

  always_comb
  begin
    ack_ok = 1'b0;
    case (kind)
      EE_K_SEL: ack_ok = ee_sel_hit(shreg, strap);
      EE_K_AHI: ack_ok = 1'b1;
      EE_K_ALO: ack_ok = 1'b1;
      EE_K_DATA:
      begin
        if (lock_cmd)
          ack_ok = !id_page_locked && shreg[`EE_LOCK_DATA_BIT];
        else if (sel_id)
          ack_ok = !id_page_locked && f_in_ready;
        else
          ack_ok = !wp_s && f_in_ready;
      end
      default: ack_ok = 1'b0;
    endcase
  end

  // a full fifo refuses the byte rather than losing it silently
  assign f_in_valid = byte_done && phase == EE_RX && kind == EE_K_DATA && ack_ok && !lock_cmd;
  assign f_out_ready = !write_busy;

  ee_fifo #(
    .W(PW + 8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({ctr[PW-1:0], shreg}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // bit engine and shared address counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase <= EE_IDLE;
      kind <= EE_K_SEL;
      bitcnt <= '0;
      ack_phase <= 1'b0;
      acked <= 1'b0;
      master_ack <= 1'b0;
      shreg <= '0;
      txbyte <= '0;
      sel_id <= 1'b0;
      addr_hi <= '0;
      ctr <= '0;
      wr_armed <= 1'b0;
      lock_pend <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (write_busy || stop_ev)
    begin
      phase <= EE_IDLE;
      ack_phase <= 1'b0;
      wr_armed <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (start_ev)
    begin
      phase <= EE_RX;
      kind <= EE_K_SEL;
      bitcnt <= '0;
      ack_phase <= 1'b0;
      wr_armed <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (scl_rise && phase != EE_IDLE)
    begin
      if (ack_phase)
        master_ack <= !sda_s;
      else if (phase == EE_RX && bitcnt != 4'h8)
      begin
        shreg <= {shreg[6:0], sda_s};
        bitcnt <= bitcnt + 4'h1;
      end
    end
    else if (byte_done)
    begin
      ack_phase <= 1'b1;
      if (phase == EE_RX)
      begin
        acked <= ack_ok;
        sda_oe_n <= !ack_ok;
        if (kind == EE_K_SEL && ack_ok)
          sel_id <= shreg[`EE_TYPE_BIT];
        if (kind == EE_K_DATA && ack_ok && lock_cmd)
          lock_pend <= 1'b1;
      end
      else
        sda_oe_n <= 1'b1;
    end
    else if (slot_end)
    begin
      ack_phase <= 1'b0;
      bitcnt <= '0;
      sda_oe_n <= 1'b1;
      if (phase == EE_TX)
      begin
        if (master_ack)
        begin
          sda_oe_n <= rd_byte[7];
          txbyte <= {rd_byte[6:0], 1'b0};
          bitcnt <= 4'h1;
          ctr <= ctr + 1'b1;
        end
        else
          phase <= EE_IDLE;
      end
      else if (!acked && kind != EE_K_DATA)
        phase <= EE_IDLE;
      else
      begin
        case (kind)
          EE_K_SEL:
          begin
            if (shreg[`EE_RW_BIT])
            begin
              phase <= EE_TX;
              sda_oe_n <= rd_byte[7];
              txbyte <= {rd_byte[6:0], 1'b0};
              bitcnt <= 4'h1;
              ctr <= ctr + 1'b1;
            end
            else
            begin
              kind <= EE_K_AHI;
              lock_pend <= 1'b0;
            end
          end
          EE_K_AHI:
          begin
            addr_hi <= shreg;
            kind <= EE_K_ALO;
          end
          EE_K_ALO:
          begin
            ctr <= ADDR_W'({addr_hi, shreg});
            kind <= EE_K_DATA;
          end
          EE_K_DATA:
          begin
            if (acked)
            begin
              wr_armed <= 1'b1;
              ctr[PW-1:0] <= ctr[PW-1:0] + 1'b1;
            end
          end
          default: phase <= EE_IDLE;
        endcase
      end
    end
    else if (scl_fall)
    begin
      // any further clock after the data ack slot disarms the write
      wr_armed <= 1'b0;
      if (phase == EE_TX && !ack_phase)
      begin
        sda_oe_n <= txbyte[7];
        txbyte <= {txbyte[6:0], 1'b0};
        bitcnt <= bitcnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    sda_out <= 1'b0;
  end

  // internal write cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      write_busy <= 1'b0;
      busy_cnt <= '0;
      id_page_locked <= 1'b0;
    end
    else if (!write_busy)
    begin
      if (stop_ev && wr_armed)
      begin
        write_busy <= 1'b1;
        busy_cnt <= CW'(TW_CYCLES - 1);
      end
    end
    else if (busy_cnt == '0)
    begin
      write_busy <= 1'b0;
      if (lock_pend)
        id_page_locked <= 1'b1;
    end
    else
      busy_cnt <= busy_cnt - 1'b1;
  end

  // page buffer fed through the fifo; the mask marks bytes to commit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pmask <= '0;
    else if (page_clr || commit)
      pmask <= '0;
    else if (f_out_valid && f_out_ready)
      pmask[f_out_data[PW+7:8]] <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (f_out_valid && f_out_ready)
      pbuf[f_out_data[PW+7:8]] <= f_out_data[7:0];
  end

  function automatic logic [GW-1:0] commit_grp(input int g);
    return grp_of(sel_id, ADDR_W'({ctr[ADDR_W-1:PW], PW'(4 * g)}));
  endfunction : commit_grp

  function automatic logic [31:0] merged(input int g);
    logic [31:0] w;
    w = ee_ecc_fix(mem[commit_grp(g)], eccm[commit_grp(g)]);
    for (int b = 0; b < 4; b++)
      if (pmask[4 * g + b])
        w[8 * b +: 8] = pbuf[4 * g + b];
    return w;
  endfunction : merged

  // whole groups are rewritten so the check bits always cover all four bytes
  always_ff @(posedge clk)
  begin
    if (commit)
      for (int g = 0; g < PGROUPS; g++)
        if (|pmask[4 * g +: 4])
        begin
          mem[commit_grp(g)] <= merged(g);
          eccm[commit_grp(g)] <= ee_ecc_gen(merged(g));
        end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  busy_sda_release_a: assert property (write_busy |-> sda_oe_n)
    else $error("sda driven during write cycle");
  wp_data_refused_a: assert property (byte_done && phase == EE_RX && kind == EE_K_DATA && !sel_id && wp_s
    |=> sda_oe_n && !acked)
    else $error("protected data byte acknowledged");
  wp_addr_acked_a: assert property (byte_done && phase == EE_RX && (kind == EE_K_AHI || kind == EE_K_ALO)
    |=> !sda_oe_n && acked)
    else $error("address byte not acknowledged");
  locked_id_refused_a: assert property (byte_done && phase == EE_RX && kind == EE_K_DATA && sel_id
    && id_page_locked |=> sda_oe_n)
    else $error("locked id page data acknowledged");
  strap_mismatch_a: assert property (byte_done && phase == EE_RX && kind == EE_K_SEL && shreg[3:1] != strap
    |=> sda_oe_n && !acked)
    else $error("select acknowledged with wrong straps");
  stray_stop_a: assert property (stop_ev && !write_busy && !wr_armed |=> !write_busy)
    else $error("stop outside data ack slot started write");
  slot_stop_a: assert property (stop_ev && !write_busy && wr_armed |=> write_busy && sda_oe_n)
    else $error("stop after data ack did not start write");
  page_step_a: assert property (slot_end && phase == EE_RX && kind == EE_K_DATA && acked
    |=> ctr[PW-1:0] == PW'($past(ctr[PW-1:0]) + 1'b1) && ctr[ADDR_W-1:PW] == $past(ctr[ADDR_W-1:PW]))
    else $error("in-page address did not step inside page");
  read_nack_idle_a: assert property (slot_end && phase == EE_TX && !master_ack |=> phase == EE_IDLE && sda_oe_n)
    else $error("no standby after master nack");
  read_step_a: assert property (slot_end && phase == EE_TX && master_ack |=> ctr == ADDR_W'($past(ctr) + 1'b1))
    else $error("read counter did not advance");
  lock_commit_a: assert property (commit && lock_pend |=> id_page_locked && !write_busy)
    else $error("lock not applied at end of write cycle");
endmodule : ee_cmd_slave

// ===== logic/ee_map.svh
// sizes, field positions, reset values and timing counts of the eeprom command slave
`ifndef EE_MAP_SVH
`define EE_MAP_SVH
`define EE_ADDR_W 16
`define EE_PAGE_BYTES 128
`define EE_FIFO_DEPTH 8
`define EE_TYPE_MEM 4'hA
`define EE_TYPE_ID 4'hB
`define EE_TYPE_BIT 4
`define EE_RW_BIT 0
`define EE_LOCK_ADDR_BIT 10
`define EE_LOCK_DATA_BIT 1
`define EE_PIN_IDLE 6'h3F
`define EE_TW_MS 5
`define EE_CLK_NS 5
`endif

// ===== logic/ee_pkg.sv
// types shared by the eeprom command slave
package ee_pkg;
  typedef enum logic [1:0] {
    EE_IDLE = 2'b00,
    EE_RX = 2'b01,
    EE_TX = 2'b10
  } ee_phase_t;

  typedef enum logic [1:0] {
    EE_K_SEL = 2'b00,
    EE_K_AHI = 2'b01,
    EE_K_ALO = 2'b10,
    EE_K_DATA = 2'b11
  } ee_kind_t;
endpackage : ee_pkg

// ===== logic/ee_fifo.sv
// small valid/ready fifo between the bit engine and the page buffer
`timescale 1ns/10ps
module ee_fifo
#(
  parameter int W = 15,
  parameter int DEPTH = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("ee_fifo depth must be a power of two");
  end

  logic [W-1:0] store [0:DEPTH-1];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = store[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      store[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : ee_fifo

// ===== bench/ee_i2c_master.sv
// behavioural i2c bus master that drives scl and sda toward the eeprom slave
`timescale 1ns/10ps
module ee_i2c_master
(
  input wire logic clk,
  input wire logic lclk,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda,
  output logic res_valid,
  output logic [7:0] res_data
);
  logic pull_low = 1'b0;
  logic [7:0] last = 8'h00;

  initial
  begin
    scl = 1'b1;
    res_valid = 1'b0;
    res_data = 8'h00;
  end

  // wired and with pull-up; an undriven slave reads as released
  assign sda = (sda_oe_n === 1'b0) ? sda_out : ~pull_low;

  // one phase is a link clock tick, so every scl level lasts well over 10 clk
  task ph;
    @(posedge lclk);
    @(posedge clk);
  endtask : ph

  task start;
    ph;
    pull_low <= 1'b0;
    ph;
    scl <= 1'b1;
    ph;
    pull_low <= 1'b1;
    ph;
    scl <= 1'b0;
  endtask : start

  task stop;
    ph;
    pull_low <= 1'b1;
    ph;
    scl <= 1'b1;
    ph;
    pull_low <= 1'b0;
    ph;
  endtask : stop

  // sda only moves a full phase after scl falls, never near the rising edge
  task xfer(input logic [7:0] d, input logic rd, input logic mack, input logic chk);
    logic [8:0] tx;
    logic [8:0] got;
    tx = rd ? {8'hFF, ~mack} : {d, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      ph;
      pull_low <= ~tx[i];
      ph;
      scl <= 1'b1;
      ph;
      got[i] = sda;
      scl <= 1'b0;
    end
    last = rd ? got[8:1] : {7'h00, got[0]};
    if (chk)
    begin
      res_data <= last;
      res_valid <= 1'b1;
      @(posedge clk);
      res_valid <= 1'b0;
    end
  endtask : xfer
endmodule : ee_i2c_master

// ===== bench/ee_cmd_slave_test.sv
// self-checking bench for the eeprom command slave
`timescale 1ns/10ps
`include "ee_map.svh"
module ee_cmd_slave_test
  import ee_pkg::*;
;
  localparam int TW = 2000;
  localparam logic [3:0] MEM = `EE_TYPE_MEM;
  localparam logic [3:0] ID = `EE_TYPE_ID;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic scl, sda, sda_out, sda_oe_n, write_busy, id_page_locked, res_valid;
  logic [7:0] res_data;
  logic [7:0] q[$];
  logic [7:0] d[10];
  logic [31:0] seed = 32'h30;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;
  initial #7 forever #32 lclk = ~lclk;

  ee_cmd_slave #(.TW_CYCLES(TW)) u_ee_cmd_slave (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect_input(wp), .chip_select_strap_bit2(cs[2]),
    .chip_select_strap_bit1(cs[1]), .chip_select_strap_bit0(cs[0]), .write_busy(write_busy),
    .id_page_locked(id_page_locked));
  ee_i2c_master u_ee_i2c_master (.clk(clk), .lclk(lclk), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .scl(scl), .sda(sda), .res_valid(res_valid), .res_data(res_data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [7:0] sl(input logic [3:0] t, input logic rw);
    return {t, cs, rw};
  endfunction : sl

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // ack results are 00 for ack and 01 for noack, read results are the byte
  always @(posedge clk)
  begin
    if (res_valid === 1'b1)
      check("bus result", res_data, (q.size() > 0) ? q.pop_front() : 8'hXX);
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 100000)
    begin
      bad_count++;
      stop_test;
    end
  end

  task st;
    u_ee_i2c_master.start;
  endtask : st

  task sp;
    u_ee_i2c_master.stop;
  endtask : sp

  task wb(input logic [7:0] v, input logic [7:0] e);
    q.push_back(e);
    u_ee_i2c_master.xfer(v, 1'b0, 1'b0, 1'b1);
  endtask : wb

  task wr(input logic [3:0] t, input logic [15:0] a, input int n, input int f, input logic [7:0] e);
    st;
    wb(sl(t, 1'b0), 8'h00);
    wb(a[15:8], 8'h00);
    wb(a[7:0], 8'h00);
    for (int i = 0; i < n; i++)
      wb(d[f + i], e);
    sp;
  endtask : wr

  // first try must be refused, later tries are unchecked until one is acked
  task poll;
    int k;
    k = 0;
    st;
    wb(sl(MEM, 1'b0), 8'h01);
    do
    begin
      st;
      u_ee_i2c_master.xfer(sl(MEM, 1'b0), 1'b0, 1'b0, 1'b0);
      k++;
    end
    while (u_ee_i2c_master.last !== 8'h00 && k < 60);
    check("poll ack", u_ee_i2c_master.last, 8'h00);
  endtask : poll

  task cur(input int n, input int f);
    st;
    wb(sl(MEM, 1'b1), 8'h00);
    for (int i = 0; i < n; i++)
    begin
      q.push_back(d[f + i]);
      u_ee_i2c_master.xfer(8'hFF, 1'b1, i < n - 1, 1'b1);
    end
    sp;
  endtask : cur

  task rd(input logic [15:0] a, input int n, input int f, input logic pol);
    if (pol)
      poll;
    else
    begin
      st;
      wb(sl(MEM, 1'b0), 8'h00);
    end
    wb(a[15:8], 8'h00);
    wb(a[7:0], 8'h00);
    cur(n, f);
  endtask : rd

  task quiet(input logic [7:0] lk);
    repeat (20) @(posedge clk);
    check("busy", {7'h00, write_busy}, 8'h00);
    check("lock", {7'h00, id_page_locked}, lk);
  endtask : quiet

  initial
  begin
    for (int i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      d[i] = seed[7:0];
    end
    d[8] = 8'hFD;
    d[9] = 8'h02;
    @(posedge clk);
    cs <= seed[10:8];
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("idle sda", {7'h00, sda_oe_n}, 8'h01);
    quiet(8'h00);
    wr(MEM, 16'h0A02, 1, 4, 8'h00);
    check("busy", {7'h00, write_busy}, 8'h01);
    rd(16'h0A02, 1, 4, 1'b1);
    wr(MEM, 16'h0A7E, 4, 0, 8'h00);
    poll;
    sp;
    quiet(8'h00);
    cur(1, 4);
    rd(16'h0A7E, 2, 0, 1'b0);
    rd(16'h0A00, 3, 2, 1'b0);
    wp <= 1'b1;
    wr(MEM, 16'h0A00, 1, 7, 8'h01);
    quiet(8'h00);
    rd(16'h0A00, 1, 2, 1'b0);
    wp <= 1'b0;
    wr(MEM, 16'hFFFF, 1, 5, 8'h00);
    poll;
    sp;
    wr(MEM, 16'h0000, 1, 6, 8'h00);
    rd(16'hFFFF, 2, 5, 1'b1);
    for (int j = 0; j < 3; j++)
    begin
      st;
      wb({MEM, cs ^ 3'(1 << j), 1'b0}, 8'h01);
      sp;
    end
    wr(ID, 16'hFB05, 1, 0, 8'h00);
    poll;
    sp;
    wr(ID, 16'h0400, 1, 8, 8'h01);
    quiet(8'h00);
    wr(ID, 16'h0400, 1, 9, 8'h00);
    poll;
    sp;
    quiet(8'h01);
    wr(ID, 16'h0005, 1, 0, 8'h01);
    quiet(8'h01);
    check("pending", 8'(q.size()), 8'h00);
    stop_test;
  end
endmodule : ee_cmd_slave_test
